// ==== src/shrb_bank.sv ====
// Purpose: Register bank holding decoded service header fields and software controls
// Assumes: Synchronous byte register port on the system clock; header fields come from same-clock logic
// Notes:   Reads return data one cycle after the read strobe
//
// Summary of operation
// RQ1 - Strategy register: upper nibble zero, lower nibble the received strategy code.
// RQ2 - Codes 0100 and 0101 are channel keys for periods A and B.
// RQ3 - First indicator register: bits 7:5 zero, indicator in bits 4:0.
// RQ4 - Second indicator register: bit 7 zero, indicator in bits 6:0.
// RQ5 - Multiframe register bit 4 is the start flag; bits 7:5 zero.
// RQ6 - With start flag set, bits 3:0 give segment count minus one.
// RQ7 - With start flag clear, bits 3:0 give segment offset.
// RQ8 - Short aux data readable as two bytes, high at 006, low at 005.
// RQ9 - Long aux data readable as eight bytes, 00E high down to 007.
// RQ10 - Component select bit 7 enables path A, bits 6:4 pick component.
// RQ11 - Component select bit 3 enables path B, bits 2:0 pick component.
// RQ12 - Only preset word zero is writable, eight write-only bytes 038 to 03F.
// RQ13 - Cipher mode bit 0: one normal operation, zero blocking enabled.
// RQ14 - Static key selector bit n enables key n for read-out.
// RQ15 - Strategy register sits at 001 and is read-only.
// RQ16 - Header fields refresh together on each valid header and then hold.
`timescale 1ns/1ns
`include "shrb_defines.svh"

module shrb_bank #(
    parameter int ADDR_W = `SHRB_ADDR_W
) (
    // Clock and reset
    input  wire logic                 i_clock,
    input  wire logic                 i_rst,
    // Register port
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    input  wire logic [7:0]           i_wdata,
    output logic      [7:0]           o_rdata,
    output logic                      o_rvalid,
    // Decoded header from the demultiplexer
    input  wire logic                 i_hdr_valid,
    input  wire shrb_pkg::shrb_header_t i_hdr,
    // Controls to the channel logic
    output shrb_pkg::shrb_path_t      o_path_a,
    output shrb_pkg::shrb_path_t      o_path_b,
    output logic                      o_normal_mode,
    output logic                      o_blocking,
    output logic      [15:0]          o_key_enable,
    output logic      [63:0]          o_preset_word,
    output logic                      o_chan_key
);

    // ==========================================
    // Address decoding
    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [2:0] byte_index(input logic [ADDR_W-1:0] a,
                                              input logic [ADDR_W-1:0] lo);
        logic [ADDR_W-1:0] d;
        d = a - lo;
        byte_index = d[2:0];
    endfunction

    // ==========================================
    // Header capture
    shrb_pkg::shrb_header_t hdr_reg;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            hdr_reg <= '0;
        end
        else if (i_hdr_valid)
        begin
            hdr_reg <= i_hdr; // [RQ16]
        end
    end

    // ==========================================
    // Software controls
    logic [7:0]  comp_sel_reg;
    logic        mode_reg;
    logic [15:0] key_sel_reg;
    logic [63:0] piw_reg;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            comp_sel_reg <= `SHRB_RST_BYTE;
        end
        else if (i_wr && i_addr == `SHRB_OFF_COMP_SEL)
        begin
            comp_sel_reg <= i_wdata; // [RQ10] [RQ11]
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_reg <= `SHRB_RST_MODE;
        end
        else if (i_wr && i_addr == `SHRB_OFF_CIPHER_MODE)
        begin
            mode_reg <= i_wdata[`SHRB_MODE_NORMAL_BIT]; // [RQ13]
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            key_sel_reg <= `SHRB_RST_KEY_SEL;
        end
        else if (i_wr && i_addr == `SHRB_OFF_KEY_SEL_LO)
        begin
            key_sel_reg[7:0] <= i_wdata; // [RQ14]
        end
        else if (i_wr && i_addr == `SHRB_OFF_KEY_SEL_HI)
        begin
            key_sel_reg[15:8] <= i_wdata; // [RQ14]
        end
    end

    // Write-only word; reads of its addresses return zero
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_piw
            always_ff @(posedge i_clock or posedge i_rst)
            begin
                if (i_rst)
                begin
                    piw_reg[g*8 +: 8] <= `SHRB_RST_BYTE;
                end
                else if (i_wr && i_addr == `SHRB_OFF_PIW_LO + ADDR_W'(g))
                begin
                    piw_reg[g*8 +: 8] <= i_wdata; // [RQ12]
                end
            end
        end
    endgenerate

    // ==========================================
    // Control outputs
    always_comb
    begin
        o_path_a.enable    = comp_sel_reg[`SHRB_SEL_A_EN_BIT]; // [RQ10]
        o_path_a.component = comp_sel_reg[6:4];
        o_path_b.enable    = comp_sel_reg[`SHRB_SEL_B_EN_BIT]; // [RQ11]
        o_path_b.component = comp_sel_reg[2:0];
    end

    assign o_normal_mode = mode_reg;       // [RQ13]
    assign o_blocking    = ~mode_reg;      // [RQ13]
    assign o_key_enable  = key_sel_reg;    // [RQ14]
    assign o_preset_word = piw_reg;        // [RQ12]
    // Channel-specific key in force for either period
    assign o_chan_key    = (hdr_reg.strategy == shrb_pkg::SHRB_STRAT_CHAN_A) ||
                           (hdr_reg.strategy == shrb_pkg::SHRB_STRAT_CHAN_B); // [RQ2]

    // ==========================================
    // Read mux
    logic [7:0] rd_next;

    always_comb
    begin
        rd_next = `SHRB_READ_ZERO;
        if (i_addr == `SHRB_OFF_STRATEGY)
        begin
            rd_next = {4'h0, hdr_reg.strategy}; // [RQ1] [RQ15]
        end
        else if (i_addr == `SHRB_OFF_IND_ONE)
        begin
            rd_next = {3'h0, hdr_reg.ind_one}; // [RQ3]
        end
        else if (i_addr == `SHRB_OFF_IND_TWO)
        begin
            rd_next = {1'h0, hdr_reg.ind_two}; // [RQ4]
        end
        else if (i_addr == `SHRB_OFF_SHORT_LO)
        begin
            rd_next = hdr_reg.data_short[7:0]; // [RQ8]
        end
        else if (i_addr == `SHRB_OFF_SHORT_HI)
        begin
            rd_next = hdr_reg.data_short[15:8]; // [RQ8]
        end
        else if (in_range(i_addr, `SHRB_OFF_LONG_LO, `SHRB_OFF_LONG_HI))
        begin
            rd_next = hdr_reg.data_long[byte_index(i_addr, `SHRB_OFF_LONG_LO)*8 +: 8]; // [RQ9]
        end
        else if (i_addr == `SHRB_OFF_COMP_SEL)
        begin
            rd_next = comp_sel_reg;
        end
        else if (i_addr == `SHRB_OFF_CIPHER_MODE)
        begin
            rd_next = {7'h00, mode_reg};
        end
        else if (i_addr == `SHRB_OFF_KEY_SEL_LO)
        begin
            rd_next = key_sel_reg[7:0];
        end
        else if (i_addr == `SHRB_OFF_KEY_SEL_HI)
        begin
            rd_next = key_sel_reg[15:8];
        end
        else if (i_addr == `SHRB_OFF_MULTIFRAME)
        begin
            // Low nibble is count-1 or offset depending on the start flag
            rd_next = {3'h0, hdr_reg.start_flag, hdr_reg.segment_field}; // [RQ5] [RQ6] [RQ7]
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata  <= `SHRB_READ_ZERO;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_rd;
            if (i_rd)
            begin
                o_rdata <= rd_next;
            end
        end
    end

    // ==========================================
    // Checks
    chk_strategy_read: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ1]
        i_rd && i_addr == `SHRB_OFF_STRATEGY |=> o_rdata == {4'h0, $past(hdr_reg.strategy)})
        else $error("strategy read mismatch");

    chk_ind_one_zero: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ3]
        i_rd && i_addr == `SHRB_OFF_IND_ONE |=> o_rdata[7:5] == 3'h0 && o_rvalid)
        else $error("indicator one upper bits set");

    chk_ind_two_zero: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ4]
        i_rd && i_addr == `SHRB_OFF_IND_TWO |=> o_rdata[7] == 1'b0)
        else $error("indicator two bit 7 set");

    chk_mf_layout: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ5]
        i_rd && i_addr == `SHRB_OFF_MULTIFRAME |=>
        o_rdata == {3'h0, $past(hdr_reg.start_flag), $past(hdr_reg.segment_field)})
        else $error("multiframe read mismatch");

    chk_hdr_capture: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ16]
        i_hdr_valid |=> hdr_reg == $past(i_hdr))
        else $error("header not captured");

    chk_hdr_hold: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ16]
        !i_hdr_valid |=> $stable(hdr_reg))
        else $error("header changed without valid");

    chk_short_hi: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ8]
        i_rd && i_addr == `SHRB_OFF_SHORT_HI && !i_hdr_valid |=> o_rdata == hdr_reg.data_short[15:8])
        else $error("short data high byte mismatch");

    chk_long_top: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ9]
        i_rd && i_addr == `SHRB_OFF_LONG_HI && !i_hdr_valid |=> o_rdata == hdr_reg.data_long[63:56])
        else $error("long data top byte mismatch");

    chk_path_a: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ10]
        i_wr && i_addr == `SHRB_OFF_COMP_SEL |=>
        o_path_a.enable == $past(i_wdata[7]) && o_path_a.component == $past(i_wdata[6:4]))
        else $error("path A select mismatch");

    chk_path_b: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ11]
        i_wr && i_addr == `SHRB_OFF_COMP_SEL |=>
        o_path_b.enable == $past(i_wdata[3]) && o_path_b.component == $past(i_wdata[2:0]))
        else $error("path B select mismatch");

    chk_piw_wo: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ12]
        i_rd && i_addr == `SHRB_OFF_PIW_HI |=> o_rdata == 8'h00)
        else $error("preset word readable");

    chk_piw_top: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ12]
        i_wr && i_addr == `SHRB_OFF_PIW_HI |=> o_preset_word[63:56] == $past(i_wdata))
        else $error("preset word top byte not written");

    chk_mode_block: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ13]
        i_wr && i_addr == `SHRB_OFF_CIPHER_MODE && !i_wdata[0] |=> o_blocking && !o_normal_mode)
        else $error("blocking not enabled");

    chk_key_hi: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ14]
        i_wr && i_addr == `SHRB_OFF_KEY_SEL_HI |=> o_key_enable[15:8] == $past(i_wdata))
        else $error("key selector high byte mismatch");

    chk_strat_ro: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ15]
        i_wr && i_addr == `SHRB_OFF_STRATEGY && !i_hdr_valid |=> $stable(hdr_reg.strategy))
        else $error("strategy register written");

    chk_chan_key: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ2]
        i_hdr_valid && i_hdr.strategy == 4'h5 |=> o_chan_key)
        else $error("channel key code not flagged");

    chk_chan_key_off: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ2]
        i_hdr_valid && i_hdr.strategy != 4'h4 && i_hdr.strategy != 4'h5 |=> !o_chan_key)
        else $error("channel key flagged for other code");

    chk_strat_zero: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ1]
        i_rd && i_addr == `SHRB_OFF_STRATEGY |=> o_rdata[7:4] == 4'h0)
        else $error("strategy upper nibble set");

    chk_ind_one_val: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ3]
        i_rd && i_addr == `SHRB_OFF_IND_ONE && !i_hdr_valid |=> o_rdata[4:0] == hdr_reg.ind_one)
        else $error("indicator one value mismatch");

    chk_ind_two_val: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ4]
        i_rd && i_addr == `SHRB_OFF_IND_TWO && !i_hdr_valid |=> o_rdata[6:0] == hdr_reg.ind_two)
        else $error("indicator two value mismatch");

    chk_seg_field: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ6] [RQ7]
        i_rd && i_addr == `SHRB_OFF_MULTIFRAME && !i_hdr_valid |=> o_rdata[3:0] == hdr_reg.segment_field)
        else $error("segment field mismatch");

    chk_short_lo: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ8]
        i_rd && i_addr == `SHRB_OFF_SHORT_LO && !i_hdr_valid |=> o_rdata == hdr_reg.data_short[7:0])
        else $error("short data low byte mismatch");

    chk_long_bottom: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ9]
        i_rd && i_addr == `SHRB_OFF_LONG_LO && !i_hdr_valid |=> o_rdata == hdr_reg.data_long[7:0])
        else $error("long data bottom byte mismatch");

    chk_piw_bottom: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ12]
        i_wr && i_addr == `SHRB_OFF_PIW_LO |=> o_preset_word[7:0] == $past(i_wdata))
        else $error("preset word bottom byte not written");

    chk_mode_normal: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ13]
        i_wr && i_addr == `SHRB_OFF_CIPHER_MODE && i_wdata[0] |=> o_normal_mode && !o_blocking)
        else $error("normal mode not selected");

    chk_mode_rsv: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ13]
        i_rd && i_addr == `SHRB_OFF_CIPHER_MODE |=> o_rdata[7:1] == 7'h00)
        else $error("cipher mode reserved bits set");

    chk_key_lo: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ14]
        i_wr && i_addr == `SHRB_OFF_KEY_SEL_LO |=> o_key_enable[7:0] == $past(i_wdata))
        else $error("key selector low byte mismatch");

    chk_key_lo_keep: assert property (@(posedge i_clock) disable iff (i_rst) // [RQ14]
        i_wr && i_addr == `SHRB_OFF_KEY_SEL_HI |=> o_key_enable[7:0] == $past(o_key_enable[7:0]))
        else $error("key selector low byte disturbed");

endmodule

// ==== src/shrb_defines.svh ====
// Purpose: Offsets, field positions and reset values of the service header register bank
// Assumes: Byte-wide register port with internal addresses
// Notes:   Definitions only
`ifndef SHRB_DEFINES_SVH
`define SHRB_DEFINES_SVH

// ==========================================
// Register offsets
`define SHRB_ADDR_W            10
`define SHRB_OFF_STRATEGY      10'h001
`define SHRB_OFF_IND_ONE       10'h002
`define SHRB_OFF_IND_TWO       10'h003
`define SHRB_OFF_SHORT_LO      10'h005
`define SHRB_OFF_SHORT_HI      10'h006
`define SHRB_OFF_LONG_LO       10'h007
`define SHRB_OFF_LONG_HI       10'h00e
`define SHRB_OFF_COMP_SEL      10'h00f
`define SHRB_OFF_CIPHER_MODE   10'h018
`define SHRB_OFF_KEY_SEL_LO    10'h019
`define SHRB_OFF_KEY_SEL_HI    10'h01a
`define SHRB_OFF_PIW_LO        10'h038
`define SHRB_OFF_PIW_HI        10'h03f
`define SHRB_OFF_MULTIFRAME    10'h041

// ==========================================
// Field positions
`define SHRB_SEL_A_EN_BIT      7
`define SHRB_SEL_B_EN_BIT      3
`define SHRB_MF_START_BIT      4
`define SHRB_MODE_NORMAL_BIT   0

// ==========================================
// Reset values
`define SHRB_RST_BYTE          8'h00
`define SHRB_RST_KEY_SEL       16'h0000
`define SHRB_RST_PIW           64'h0000_0000_0000_0000
`define SHRB_RST_MODE          1'b0
`define SHRB_READ_ZERO         8'h00

`endif

// ==== src/shrb_pkg.sv ====
// Purpose: Types shared by the service header register bank
// Assumes: Nothing beyond the defines header
// Notes:   Types only
package shrb_pkg;

    // Fields decoded from one service control header
    typedef struct packed {
        logic [3:0]  strategy;
        logic [4:0]  ind_one;
        logic [6:0]  ind_two;
        logic        start_flag;
        logic [3:0]  segment_field;
        logic [15:0] data_short;
        logic [63:0] data_long;
    } shrb_header_t;

    // Strategy codes
    typedef enum logic [3:0] {
        SHRB_STRAT_NONE     = 4'h0,
        SHRB_STRAT_STATIC   = 4'h1,
        SHRB_STRAT_COMMON_A = 4'h2,
        SHRB_STRAT_CHAN_A   = 4'h4,
        SHRB_STRAT_CHAN_B   = 4'h5
    } shrb_strategy_t;

    // Decoded component selection path
    typedef struct packed {
        logic       enable;
        logic [2:0] component;
    } shrb_path_t;

endpackage

// ==== tb/service_header_register_bank_tb_top.sv ====
// Purpose: Self-checking bench for the service header register bank
// Assumes: Byte register port with one-cycle read latency, inputs driven at falling edge
// Notes:   Header fields are swept through every listed code and a reserved one
`timescale 1ns/1ns
`include "shrb_defines.svh"

module service_header_register_bank_tb_top;

    // ==========================================
    // Signals
    logic                  i_clock;
    logic                  i_rst;
    logic [9:0]            i_addr;
    logic                  i_wr;
    logic                  i_rd;
    logic [7:0]            i_wdata;
    logic [7:0]            o_rdata;
    logic                  o_rvalid;
    logic                  i_hdr_valid;
    shrb_pkg::shrb_header_t i_hdr;
    shrb_pkg::shrb_path_t  o_path_a;
    shrb_pkg::shrb_path_t  o_path_b;
    logic                  o_normal_mode;
    logic                  o_blocking;
    logic [15:0]           o_key_enable;
    logic [63:0]           o_preset_word;
    logic                  o_chan_key;
    int                    miscompares;
    int                    tests_run;
    shrb_pkg::shrb_header_t h;
    logic [3:0]            codes [6];

    shrb_bank uut (
        .i_clock       (i_clock),
        .i_rst         (i_rst),
        .i_addr        (i_addr),
        .i_wr          (i_wr),
        .i_rd          (i_rd),
        .i_wdata       (i_wdata),
        .o_rdata       (o_rdata),
        .o_rvalid      (o_rvalid),
        .i_hdr_valid   (i_hdr_valid),
        .i_hdr         (i_hdr),
        .o_path_a      (o_path_a),
        .o_path_b      (o_path_b),
        .o_normal_mode (o_normal_mode),
        .o_blocking    (o_blocking),
        .o_key_enable  (o_key_enable),
        .o_preset_word (o_preset_word),
        .o_chan_key    (o_chan_key)
    );

    initial
    begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // ==========================================
    // Tasks
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge i_clock);
        i_addr  = a;
        i_wdata = d;
        i_wr    = 1'b1;
        @(negedge i_clock);
        i_wr    = 1'b0;
    endtask

    // Read one byte and compare; rvalid is looked at in its single cycle
    task automatic rdc(input logic [9:0] a, input logic [7:0] exp, input string nm);
        @(negedge i_clock);
        i_addr = a;
        i_rd   = 1'b1;
        @(negedge i_clock);
        i_rd   = 1'b0;
        chk("rvalid", 64'h1, {63'h0, o_rvalid});
        chk(nm, {56'h0, exp}, {56'h0, o_rdata});
    endtask

    task automatic send_hdr(input shrb_pkg::shrb_header_t v);
        @(negedge i_clock);
        i_hdr       = v;
        i_hdr_valid = 1'b1;
        @(negedge i_clock);
        i_hdr_valid = 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Whole run is a few hundred cycles; allow generous margin
    initial
    begin
        #(100 * 20000);
        miscompares++;
        tally_and_finish();
    end

    // ==========================================
    // Tests
    initial
    begin
        miscompares = 0;
        tests_run   = 0;
        i_rst = 1'b1;
        i_addr = 10'h000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_wdata = 8'h00;
        i_hdr_valid = 1'b0;
        i_hdr = '0;
        codes = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hf};
        repeat (12) @(negedge i_clock);
        i_rst = 1'b0;
        chk("reset blocking", 64'h1, {63'h0, o_blocking});
        chk("reset path a", 64'h0, {60'h0, o_path_a});
        // Header sweep: each listed strategy code and a reserved one, low and all-ones indicators, both start flag settings
        for (int i = 0; i < 6; i++)
        begin
            h.strategy      = codes[i];
            h.ind_one       = (i == 5) ? 5'h1f : 5'(i % 4);
            h.ind_two       = (i == 5) ? 7'h7f : 7'(i % 3);
            h.start_flag    = i[0];
            h.segment_field = i[2] ? 4'hf : 4'h0;
            h.data_short    = 16'hc3a5 + 16'(i);
            h.data_long     = 64'hfedc_ba98_7654_3210 + 64'(i);
            send_hdr(h);
            chk("chan key", {63'h0, (codes[i] == 4'h4) || (codes[i] == 4'h5)}, {63'h0, o_chan_key});
            rdc(`SHRB_OFF_STRATEGY, {4'h0, h.strategy}, "strategy");
            rdc(`SHRB_OFF_IND_ONE, {3'h0, h.ind_one}, "ind one");
            rdc(`SHRB_OFF_IND_TWO, {1'h0, h.ind_two}, "ind two");
            rdc(`SHRB_OFF_MULTIFRAME, {3'h0, h.start_flag, h.segment_field}, "multiframe");
            rdc(`SHRB_OFF_SHORT_LO, h.data_short[7:0], "short lo");
            rdc(`SHRB_OFF_SHORT_HI, h.data_short[15:8], "short hi");
            for (int b = 0; b < 8; b++)
                rdc(10'h007 + 10'(b), h.data_long[8*b +: 8], "long byte");
        end
        // Fields hold while no new header is flagged
        @(negedge i_clock);
        i_hdr = ~h;
        rdc(`SHRB_OFF_STRATEGY, {4'h0, h.strategy}, "strategy hold");
        rdc(10'h00e, h.data_long[63:56], "long hold");
        wr(`SHRB_OFF_STRATEGY, 8'h03);
        rdc(`SHRB_OFF_STRATEGY, {4'h0, h.strategy}, "strategy ro");
        rdc(10'h004, 8'h00, "unmapped");
        // Component selection
        wr(`SHRB_OFF_COMP_SEL, 8'ha5);
        chk("path a", 64'ha, {60'h0, o_path_a});
        chk("path b", 64'h5, {60'h0, o_path_b});
        rdc(`SHRB_OFF_COMP_SEL, 8'ha5, "comp sel");
        wr(`SHRB_OFF_COMP_SEL, 8'h7f);
        chk("path a off", 64'h7, {60'h0, o_path_a});
        chk("path b on", 64'hf, {60'h0, o_path_b});
        // Preset word is write-only and reads as zero
        for (int b = 0; b < 8; b++)
            wr(`SHRB_OFF_PIW_LO + 10'(b), 8'h11 * 8'(b + 1));
        chk("preset", 64'h8877_6655_4433_2211, o_preset_word);
        rdc(`SHRB_OFF_PIW_HI, 8'h00, "preset wo");
        // Cipher mode
        wr(`SHRB_OFF_CIPHER_MODE, 8'h01);
        chk("normal", 64'h2, {62'h0, o_normal_mode, o_blocking});
        rdc(`SHRB_OFF_CIPHER_MODE, 8'h01, "mode rd");
        wr(`SHRB_OFF_CIPHER_MODE, 8'hfe);
        chk("blocking", 64'h1, {62'h0, o_normal_mode, o_blocking});
        rdc(`SHRB_OFF_CIPHER_MODE, 8'h00, "mode rsv");
        // Static key selector
        wr(`SHRB_OFF_KEY_SEL_LO, 8'h01);
        wr(`SHRB_OFF_KEY_SEL_HI, 8'h80);
        chk("key enable", 64'h8001, {48'h0, o_key_enable});
        rdc(`SHRB_OFF_KEY_SEL_HI, 8'h80, "key hi");
        rdc(`SHRB_OFF_KEY_SEL_LO, 8'h01, "key lo");
        tally_and_finish();
    end

endmodule
